// ---- hdl/vsd_pkg.sv ----
/*
  Package for the video sync and display control register tail: register
  offsets, field positions, reset values and the packed carriers.
  Assumes the embedded controller reaches these registers over its internal
  control register port, with the serial sub-bus registers in SFR space.
*/
package vsd_pkg;

  // ---------------------------------------------------------------------
  // Control register offsets (10-bit control space)
  // ---------------------------------------------------------------------
  localparam logic [9:0] ADDR_TEST_LUMA = 10'h33b;
  localparam logic [9:0] ADDR_TEST_CHROMA = 10'h33c;
  localparam logic [9:0] ADDR_VINT_LINE = 10'h385;
  localparam logic [9:0] ADDR_HOLD_BEGIN = 10'h386;
  localparam logic [9:0] ADDR_HOLD_END = 10'h387;
  localparam logic [9:0] ADDR_DISPLAY_OPT = 10'h388;
  localparam logic [9:0] ADDR_RSVD_A = 10'h389;
  localparam logic [9:0] ADDR_ACQ_CLEAR = 10'h38a;
  localparam logic [9:0] ADDR_COPY_STROBE = 10'h38b;
  localparam logic [9:0] ADDR_VDRIVE_SET = 10'h38c;
  localparam logic [9:0] ADDR_VDRIVE_CLEAR = 10'h38d;
  localparam logic [9:0] ADDR_LINE_CLEAR = 10'h38e;
  localparam logic [9:0] ADDR_INT1_CLEAR = 10'h38f;
  localparam logic [9:0] ADDR_DISP_CLEAR = 10'h390;
  localparam logic [9:0] ADDR_CLOCK_SEL = 10'h391;
  localparam logic [9:0] ADDR_BUSB_FIELD = 10'h392;
  localparam logic [9:0] ADDR_LINE_QUARTER = 10'h393;
  localparam logic [9:0] ADDR_FIELD_RESTART = 10'h394;
  localparam logic [9:0] ADDR_ANALOG_SW = 10'h395;
  localparam logic [9:0] ADDR_RSVD_B = 10'h396;
  localparam logic [9:0] ADDR_RSVD_C = 10'h397;
  localparam logic [9:0] ADDR_CONV_TEST = 10'h398;

  // ---------------------------------------------------------------------
  // Serial sub-bus SFR offsets (8-bit SFR space)
  // ---------------------------------------------------------------------
  localparam logic [7:0] SFR_SUBBUS_CONTROL = 8'h98;
  localparam logic [7:0] SFR_SUBBUS_TX_ADDR = 8'h99;
  localparam logic [7:0] SFR_SUBBUS_TX_DATA = 8'h9a;
  localparam logic [7:0] SFR_SUBBUS_RX_DATA = 8'h9b;

  // ---------------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------------
  localparam int CTL_TX_BUSY_BIT = 0;
  localparam int CTL_RX_BUSY_BIT = 1;
  localparam int CTL_RATE_BIT = 7;
  localparam int CLOCK_SEL_BIT = 0;
  localparam int FIELD_RESTART_BIT = 0;
  localparam int SHIFT_TAPS = 4;
  localparam logic [8:0] RST_WORD9 = 9'h000;
  localparam logic [7:0] RST_WORD8 = 8'h00;
  localparam logic [2:0] RST_CONV_TEST = 3'h0;

  // ---------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------
  // Display options, laid out as the register's bits 7..0
  typedef struct packed {
    logic horiz_sides;
    logic horiz_bars;
    logic vert_sides;
    logic vert_bars;
    logic pixel_repeat;
    logic blank_reset;
    logic [1:0] pixel_fetch_shift;
  } vsd_display_s;

  // Converter test mode, laid out as the register's bits 2..0
  typedef struct packed {
    logic converter_direct_bypass;
    logic converter_test_one;
    logic converter_test_two;
  } vsd_conv_test_s;

  // One-cycle trigger pulses towards the video logic
  typedef struct packed {
    logic acq_window_clear;
    logic value_copy;
    logic display_window_clear;
  } vsd_trigger_s;

endpackage

// ---- hdl/vsd_control_regs.sv ----
/*
  Video sync and display control register tail: write-only control words,
  write-triggered strobes, the vertical line counter with interrupt 1,
  the PLL hold window, double-buffered line length, test captures and the
  serial sub-bus control SFRs.
  Assumes a synchronous controller register port on the back-end clock, one
  access per cycle, and video timing pulses synchronous to the same clock.
*/
// Contract
// - Interrupt 1 rises when the line counter reaches the programmed interrupt line.
// - PLL frequency hold is active between programmed begin and end lines.
// - Display option bits 1:0 delay the read enable by zero to three pixels.
// - Display option bits 2..7 enable blank reset, repetition, bars and sides.
// - Writing the acquisition window clear address pulses the acquisition reset.
// - Writing the copy strobe address transfers staged values to working copies.
// - Writing the flyback trigger address sets vertical drive.
// - Writing the scan trigger address clears vertical drive.
// - Writing the line counter clear address zeroes the vertical line counter.
// - Writing the interrupt 1 clear address drops pending interrupt 1.
// - Writing the display window clear address pulses the display window reset.
// - Clock select bit 0 picks 32 MHz at zero, 16 MHz at one.
// - A nine-bit register holds the second bus start-of-field line.
// - Line quarter length is staged and taken in at start of active video.
// - Staged line quarter updates at start of active video, hold bounds at acquisition pulse, both on copy.
// - Two read-only registers capture luma and chroma words from bus D.
// - Converter test bits enable ADC and DAC tests and direct bypass.
// - Sub-bus control bit 0 reads transmit busy, bit 1 receive busy, writable.
// - Sub-bus control bit 7 selects 1 MHz at zero, 2 MHz at one.
// - Power-on reset clears the sub-bus control register.
// - Transmit address and data are written; received data read after completion.
`timescale 1ns/10ps

module vsd_control_regs (
  input wire logic i_clock, // Back-end clock
  input wire logic i_reset_n, // Asynchronous reset, active low
  input wire logic i_wr_en, // Register write strobe
  input wire logic i_rd_en, // Register read strobe
  input wire logic i_sfr_sel, // Access goes to SFR space
  input wire logic [9:0] i_addr, // Register address
  input wire logic [8:0] i_wdata, // Write data
  output logic [8:0] o_rdata, // Read data, valid the cycle after i_rd_en
  input wire logic i_line_start, // One pulse per video line
  input wire logic i_active_start, // Start of active video pulse
  input wire logic i_active_end, // End of active video pulse
  input wire logic i_vertical_acquisition_pulse, // Vertical acquisition pulse
  input wire logic i_read_enable, // Undelayed output read enable
  input wire logic [7:0] i_bus_d_luma, // Bus D luma word
  input wire logic [7:0] i_bus_d_chroma, // Bus D chroma word
  input wire logic i_power_on_reset, // Power-on reset flag of the system register
  input wire logic i_transmit_busy, // Sub-bus transmitter busy
  input wire logic i_inbound_start, // Sub-bus reception begins
  input wire logic i_inbound_done, // Sub-bus reception complete
  input wire logic [7:0] i_inbound_data, // Received sub-bus data
  output logic [8:0] o_vertical_line_counter, // Current line count
  output logic o_interrupt_one, // Pending interrupt 1
  output logic o_pll_hold, // PLL frequency hold window
  output logic o_read_enable, // Read enable after pixel shift
  output vsd_pkg::vsd_display_s o_display, // Display options
  output vsd_pkg::vsd_trigger_s o_trigger, // Trigger pulses
  output logic o_vertical_drive, // Vertical drive output
  output logic o_backend_clock_half, // High selects 16 MHz back-end clock
  output logic [8:0] o_second_bus_field_start, // Bus B field reference line
  output logic [7:0] o_line_quarter_length, // Working line quarter length
  output logic o_field_restart, // Field restart control
  output logic [7:0] o_analog_path_switch, // Analog path switches
  output vsd_pkg::vsd_conv_test_s o_conv_test, // Converter test mode
  output logic o_bit_rate_select, // High selects 2 MHz sub-bus rate
  output logic [7:0] o_subbus_tx_address, // Message address to send
  output logic [7:0] o_subbus_tx_data, // Message data to send
  output logic o_subbus_tx_start // Pulse after message data write
);

  // -----------------------------------------------------------------------
  // Address decode
  // -----------------------------------------------------------------------
  logic ctl_wr;
  logic sfr_wr;
  logic [7:0] sfr_addr;

  // Split writes between control space and SFR space
  assign ctl_wr = i_wr_en && !i_sfr_sel;
  assign sfr_wr = i_wr_en && i_sfr_sel;
  assign sfr_addr = i_addr[7:0];

  // -----------------------------------------------------------------------
  // Write-only control words
  // -----------------------------------------------------------------------
  logic [8:0] vint_line_reg;
  logic [8:0] hold_begin_reg;
  logic [8:0] hold_end_reg;
  logic [8:0] busb_field_reg;
  logic [7:0] analog_sw_reg;
  logic clock_sel_reg;
  logic field_restart_reg;
  vsd_pkg::vsd_display_s display_reg;
  vsd_pkg::vsd_conv_test_s conv_test_reg;

  // Store each control word on a write to its address
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      vint_line_reg <= vsd_pkg::RST_WORD9;
      hold_begin_reg <= vsd_pkg::RST_WORD9;
      hold_end_reg <= vsd_pkg::RST_WORD9;
      busb_field_reg <= vsd_pkg::RST_WORD9;
      analog_sw_reg <= vsd_pkg::RST_WORD8;
      clock_sel_reg <= 1'b0;
      field_restart_reg <= 1'b0;
      display_reg <= vsd_pkg::RST_WORD8;
      conv_test_reg <= vsd_pkg::RST_CONV_TEST;
    end else if (ctl_wr) begin
      unique case (i_addr)
        vsd_pkg::ADDR_VINT_LINE: vint_line_reg <= i_wdata;
        vsd_pkg::ADDR_HOLD_BEGIN: hold_begin_reg <= i_wdata;
        vsd_pkg::ADDR_HOLD_END: hold_end_reg <= i_wdata;
        vsd_pkg::ADDR_DISPLAY_OPT: display_reg <= i_wdata[7:0];
        vsd_pkg::ADDR_CLOCK_SEL: clock_sel_reg <= i_wdata[vsd_pkg::CLOCK_SEL_BIT];
        vsd_pkg::ADDR_BUSB_FIELD: busb_field_reg <= i_wdata;
        vsd_pkg::ADDR_FIELD_RESTART: begin
          field_restart_reg <= i_wdata[vsd_pkg::FIELD_RESTART_BIT];
        end
        vsd_pkg::ADDR_ANALOG_SW: analog_sw_reg <= i_wdata[7:0];
        vsd_pkg::ADDR_CONV_TEST: conv_test_reg <= i_wdata[2:0];
        default: begin
        end
      endcase
    end
  end

  // -----------------------------------------------------------------------
  // Trigger strobes
  // -----------------------------------------------------------------------
  logic trig_acq;
  logic trig_copy;
  logic trig_vset;
  logic trig_vclear;
  logic trig_line_clear;
  logic trig_int_clear;
  logic trig_disp;

  // Address match alone fires a trigger; the data is ignored
  assign trig_acq = ctl_wr && (i_addr == vsd_pkg::ADDR_ACQ_CLEAR);
  assign trig_copy = ctl_wr && (i_addr == vsd_pkg::ADDR_COPY_STROBE);
  assign trig_vset = ctl_wr && (i_addr == vsd_pkg::ADDR_VDRIVE_SET);
  assign trig_vclear = ctl_wr && (i_addr == vsd_pkg::ADDR_VDRIVE_CLEAR);
  assign trig_line_clear = ctl_wr && (i_addr == vsd_pkg::ADDR_LINE_CLEAR);
  assign trig_int_clear = ctl_wr && (i_addr == vsd_pkg::ADDR_INT1_CLEAR);
  assign trig_disp = ctl_wr && (i_addr == vsd_pkg::ADDR_DISP_CLEAR);

  vsd_pkg::vsd_trigger_s trigger_reg;

  // Register the window pulses so each lasts exactly one clock
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      trigger_reg <= '0;
    end else begin
      trigger_reg.acq_window_clear <= trig_acq;
      trigger_reg.value_copy <= trig_copy;
      trigger_reg.display_window_clear <= trig_disp;
    end
  end

  // -----------------------------------------------------------------------
  // Vertical drive
  // -----------------------------------------------------------------------
  logic vdrive_reg;

  // Flyback trigger sets, scan trigger clears
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      vdrive_reg <= 1'b0;
    end else if (trig_vset) begin
      vdrive_reg <= 1'b1;
    end else if (trig_vclear) begin
      vdrive_reg <= 1'b0;
    end
  end

  // -----------------------------------------------------------------------
  // Vertical line counter and interrupt 1
  // -----------------------------------------------------------------------
  logic [8:0] line_count_reg;
  logic [8:0] line_count_next;
  logic int1_reg;
  logic int1_hit;

  // Count lines; a clear trigger wins over a line pulse
  assign line_count_next = line_count_reg + 9'h001;

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      line_count_reg <= vsd_pkg::RST_WORD9;
    end else if (trig_line_clear) begin
      line_count_reg <= vsd_pkg::RST_WORD9;
    end else if (i_line_start) begin
      line_count_reg <= line_count_next;
    end
  end

  // Compare on the step into the programmed line
  assign int1_hit = i_line_start && !trig_line_clear && (line_count_next == vint_line_reg);

  // Pending flag: a hit in the clearing cycle keeps it set
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      int1_reg <= 1'b0;
    end else if (int1_hit) begin
      int1_reg <= 1'b1;
    end else if (trig_int_clear) begin
      int1_reg <= 1'b0;
    end
  end

  // -----------------------------------------------------------------------
  // PLL hold window
  // -----------------------------------------------------------------------
  logic [8:0] hold_begin_work_reg;
  logic [8:0] hold_end_work_reg;
  logic pll_hold_reg;

  // Working bounds follow the acquisition pulse or the copy trigger
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      hold_begin_work_reg <= vsd_pkg::RST_WORD9;
      hold_end_work_reg <= vsd_pkg::RST_WORD9;
    end else if (i_vertical_acquisition_pulse || trig_copy) begin
      hold_begin_work_reg <= hold_begin_reg;
      hold_end_work_reg <= hold_end_reg;
    end
  end

  // Hold from the begin line up to, not including, the end line
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pll_hold_reg <= 1'b0;
    end else begin
      pll_hold_reg <= (line_count_reg >= hold_begin_work_reg) &&
                      (line_count_reg < hold_end_work_reg);
    end
  end

  // -----------------------------------------------------------------------
  // Pixel shift of the read enable
  // -----------------------------------------------------------------------
  logic [vsd_pkg::SHIFT_TAPS-1:0] re_taps;

  // Tap 0 is the live input; each later tap is one pixel later
  assign re_taps[0] = i_read_enable;

  genvar tap;
  generate
    for (tap = 1; tap < vsd_pkg::SHIFT_TAPS; tap = tap + 1) begin : g_shift
      always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
          re_taps[tap] <= 1'b0;
        end else begin
          re_taps[tap] <= re_taps[tap-1];
        end
      end
    end
  endgenerate

  // Select the tap named by the shift field
  assign o_read_enable = re_taps[display_reg.pixel_fetch_shift];

  // -----------------------------------------------------------------------
  // Double-buffered line quarter length
  // -----------------------------------------------------------------------
  logic [7:0] quarter_stage_reg;
  logic [7:0] quarter_work_reg;

  // Staged on write
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      quarter_stage_reg <= vsd_pkg::RST_WORD8;
    end else if (ctl_wr && (i_addr == vsd_pkg::ADDR_LINE_QUARTER)) begin
      quarter_stage_reg <= i_wdata[7:0];
    end
  end

  // Taken in at start of active video or on the copy trigger
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      quarter_work_reg <= vsd_pkg::RST_WORD8;
    end else if (i_active_start || trig_copy) begin
      quarter_work_reg <= quarter_stage_reg;
    end
  end

  // -----------------------------------------------------------------------
  // Bus D test captures
  // -----------------------------------------------------------------------
  logic [7:0] luma_cap_reg;
  logic [7:0] chroma_cap_reg;

  // Captured at end of active video so the readback is stable
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      luma_cap_reg <= vsd_pkg::RST_WORD8;
      chroma_cap_reg <= vsd_pkg::RST_WORD8;
    end else if (i_active_end) begin
      luma_cap_reg <= i_bus_d_luma;
      chroma_cap_reg <= i_bus_d_chroma;
    end
  end

  // -----------------------------------------------------------------------
  // Serial sub-bus SFRs
  // -----------------------------------------------------------------------
  logic rx_busy_reg;
  logic rate_reg;
  logic [7:0] tx_addr_reg;
  logic [7:0] tx_data_reg;
  logic tx_start_reg;
  logic [7:0] rx_data_reg;
  logic ctl_sfr_wr;

  assign ctl_sfr_wr = sfr_wr && (sfr_addr == vsd_pkg::SFR_SUBBUS_CONTROL);

  // Control bits; power-on reset clears, a reception start wins over writes
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rx_busy_reg <= 1'b0;
      rate_reg <= 1'b0;
    end else if (i_power_on_reset) begin
      rx_busy_reg <= 1'b0;
      rate_reg <= 1'b0;
    end else begin
      if (i_inbound_start) begin
        rx_busy_reg <= 1'b1;
      end else if (ctl_sfr_wr) begin
        rx_busy_reg <= i_wdata[vsd_pkg::CTL_RX_BUSY_BIT];
      end else if (i_inbound_done) begin
        rx_busy_reg <= 1'b0;
      end
      if (ctl_sfr_wr) begin
        rate_reg <= i_wdata[vsd_pkg::CTL_RATE_BIT];
      end
    end
  end

  // Outgoing message; writing the data launches it
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tx_addr_reg <= vsd_pkg::RST_WORD8;
      tx_data_reg <= vsd_pkg::RST_WORD8;
      tx_start_reg <= 1'b0;
    end else begin
      tx_start_reg <= sfr_wr && (sfr_addr == vsd_pkg::SFR_SUBBUS_TX_DATA);
      if (sfr_wr && (sfr_addr == vsd_pkg::SFR_SUBBUS_TX_ADDR)) begin
        tx_addr_reg <= i_wdata[7:0];
      end
      if (sfr_wr && (sfr_addr == vsd_pkg::SFR_SUBBUS_TX_DATA)) begin
        tx_data_reg <= i_wdata[7:0];
      end
    end
  end

  // Received data is taken when the reception completes
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rx_data_reg <= vsd_pkg::RST_WORD8;
    end else if (i_inbound_done) begin
      rx_data_reg <= i_inbound_data;
    end
  end

  // -----------------------------------------------------------------------
  // Read path
  // -----------------------------------------------------------------------
  logic [8:0] rdata_reg;
  logic [8:0] rdata_next;

  // Readable registers only; write-only and unmapped read as zero
  always_comb begin
    rdata_next = 9'h000;
    if (i_sfr_sel) begin
      unique case (sfr_addr)
        vsd_pkg::SFR_SUBBUS_CONTROL: begin
          rdata_next[vsd_pkg::CTL_TX_BUSY_BIT] = i_transmit_busy;
          rdata_next[vsd_pkg::CTL_RX_BUSY_BIT] = rx_busy_reg;
          rdata_next[vsd_pkg::CTL_RATE_BIT] = rate_reg;
        end
        vsd_pkg::SFR_SUBBUS_RX_DATA: rdata_next = {1'b0, rx_data_reg};
        default: rdata_next = 9'h000;
      endcase
    end else begin
      unique case (i_addr)
        vsd_pkg::ADDR_TEST_LUMA: rdata_next = {1'b0, luma_cap_reg};
        vsd_pkg::ADDR_TEST_CHROMA: rdata_next = {1'b0, chroma_cap_reg};
        default: rdata_next = 9'h000;
      endcase
    end
  end

  // Read data is held until the next read
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rdata_reg <= 9'h000;
    end else if (i_rd_en) begin
      rdata_reg <= rdata_next;
    end
  end

  // -----------------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------------
  assign o_rdata = rdata_reg;
  assign o_vertical_line_counter = line_count_reg;
  assign o_interrupt_one = int1_reg;
  assign o_pll_hold = pll_hold_reg;
  assign o_display = display_reg;
  assign o_trigger = trigger_reg;
  assign o_vertical_drive = vdrive_reg;
  assign o_backend_clock_half = clock_sel_reg;
  assign o_second_bus_field_start = busb_field_reg;
  assign o_line_quarter_length = quarter_work_reg;
  assign o_field_restart = field_restart_reg;
  assign o_analog_path_switch = analog_sw_reg;
  assign o_conv_test = conv_test_reg;
  assign o_bit_rate_select = rate_reg;
  assign o_subbus_tx_address = tx_addr_reg;
  assign o_subbus_tx_data = tx_data_reg;
  assign o_subbus_tx_start = tx_start_reg;

endmodule // vsd_control_regs

// ---- bench/vsd_properties.sv ----
/*
  Checker for the control register tail: trigger strobes, vertical drive,
  line counter and interrupt 1.
  Assumes one back-end clock and an asynchronous active-low reset.
*/
`timescale 1ns/10ps
module vsd_properties (
  input wire logic i_clock, // Back-end clock
  input wire logic i_reset_n, // Reset, active low
  input wire logic i_wr_en, // Write strobe
  input wire logic i_sfr_sel, // SFR space select
  input wire logic [9:0] i_addr, // Address
  input wire logic i_line_start, // Line pulse
  input wire logic [8:0] o_vertical_line_counter, // Line count
  input wire logic o_interrupt_one, // Interrupt 1
  input wire logic o_vertical_drive, // Vertical drive
  input wire vsd_pkg::vsd_trigger_s o_trigger // Trigger pulses
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  // Control-space write decode
  logic cw;
  assign cw = i_wr_en & ~i_sfr_sel;
  a_vdrive_set: assert property (
    cw && i_addr == 10'h38c |=> o_vertical_drive) else $error("vdrive not set");
  a_vdrive_clear: assert property (
    cw && i_addr == 10'h38d |=> !o_vertical_drive) else $error("vdrive not cleared");
  a_counter_clear: assert property (
    cw && i_addr == 10'h38e |=> o_vertical_line_counter == 9'h000) else $error("count kept");
  a_counter_step: assert property (
    i_line_start && !(cw && i_addr == 10'h38e) |=>
    o_vertical_line_counter == $past(o_vertical_line_counter) + 9'h001) else $error("no step");
  a_int_cause: assert property (
    $rose(o_interrupt_one) |-> $past(i_line_start)) else $error("interrupt without line");
  a_int_clear: assert property (
    cw && i_addr == 10'h38f && !i_line_start |=> !o_interrupt_one) else $error("int kept");
  a_acq_pulse: assert property (
    cw && i_addr == 10'h38a |=> o_trigger.acq_window_clear) else $error("no acq pulse");
  a_copy_pulse: assert property (
    cw && i_addr == 10'h38b |=> o_trigger.value_copy) else $error("no copy pulse");
  a_disp_pulse: assert property (
    o_trigger.display_window_clear |-> $past(cw && i_addr == 10'h390)) else $error("stray pulse");
  c_interrupt: cover property (o_interrupt_one);
  c_copy: cover property (o_trigger.value_copy);
  c_vdrive: cover property (o_vertical_drive);
endmodule // vsd_properties

bind vsd_control_regs vsd_properties u_props (.i_clock(i_clock), .i_reset_n(i_reset_n),
  .i_wr_en(i_wr_en), .i_sfr_sel(i_sfr_sel), .i_addr(i_addr), .i_line_start(i_line_start),
  .o_vertical_line_counter(o_vertical_line_counter), .o_interrupt_one(o_interrupt_one),
  .o_vertical_drive(o_vertical_drive), .o_trigger(o_trigger));

// ---- bench/tb.sv ----
/*
  Testbench for the control register tail: register accesses and video pulses.
  Assumes vsd_pkg and the checker; inputs change at the falling edge.
*/
`timescale 1ns/10ps
module tb;
  logic i_clock = 0, i_reset_n = 0, i_wr_en = 0, i_rd_en = 0, i_sfr_sel = 0, i_line_start = 0;
  logic i_active_start = 0, i_active_end = 0, i_vertical_acquisition_pulse = 0;
  logic i_read_enable = 0, i_power_on_reset = 0, i_transmit_busy = 0, i_inbound_start = 0;
  logic i_inbound_done = 0;
  logic [9:0] i_addr = '0;
  logic [8:0] i_wdata = '0, o_rdata, o_vertical_line_counter, o_second_bus_field_start;
  logic [7:0] i_bus_d_luma = '0, i_bus_d_chroma = '0, i_inbound_data = '0, o_line_quarter_length;
  logic [7:0] o_analog_path_switch, o_subbus_tx_address, o_subbus_tx_data;
  logic o_interrupt_one, o_pll_hold, o_read_enable, o_vertical_drive, o_backend_clock_half;
  logic o_field_restart, o_bit_rate_select, o_subbus_tx_start;
  vsd_pkg::vsd_display_s o_display;
  vsd_pkg::vsd_trigger_s o_trigger;
  vsd_pkg::vsd_conv_test_s o_conv_test;
  int err_total = 0, samples_checked = 0;
  localparam logic [9:0] TA [3] = '{10'h38a, 10'h38b, 10'h390};
  vsd_control_regs i_dut (.i_clock, .i_reset_n, .i_wr_en, .i_rd_en, .i_sfr_sel, .i_addr,
    .i_wdata, .o_rdata, .i_line_start, .i_active_start, .i_active_end,
    .i_vertical_acquisition_pulse, .i_read_enable, .i_bus_d_luma, .i_bus_d_chroma,
    .i_power_on_reset, .i_transmit_busy, .i_inbound_start, .i_inbound_done, .i_inbound_data,
    .o_vertical_line_counter, .o_interrupt_one, .o_pll_hold, .o_read_enable, .o_display,
    .o_trigger, .o_vertical_drive, .o_backend_clock_half, .o_second_bus_field_start,
    .o_line_quarter_length, .o_field_restart, .o_analog_path_switch, .o_conv_test,
    .o_bit_rate_select, .o_subbus_tx_address, .o_subbus_tx_data, .o_subbus_tx_start);
  // Clock and watchdog
  always #5 i_clock = ~i_clock;
  initial begin
    #100000;
    err_total++;
    stop_test;
  end
  task tick;
    @(negedge i_clock);
  endtask
  task chk(input logic [8:0] g, input logic [8:0] e);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // One register access, held over one rising edge
  task acc(input logic w, input logic s, input logic [9:0] a, input logic [8:0] d);
    tick;
    {i_wr_en, i_rd_en, i_sfr_sel, i_addr, i_wdata} = {w, !w, s, a, d};
    tick;
    {i_wr_en, i_rd_en} = 2'h0;
  endtask
  task t_ctrl;
    acc(1, 0, 10'h38c, 0);
    chk(o_vertical_drive, 1);
    acc(1, 0, 10'h38d, 9'h1ff);
    chk(o_vertical_drive, 0);
    acc(1, 0, 10'h385, 9'h003);
    repeat (3) begin
      i_line_start = 1;
      tick;
      i_line_start = 0;
      tick;
    end
    chk(o_vertical_line_counter, 9'h003);
    chk(o_interrupt_one, 1);
    acc(1, 0, 10'h38f, 0);
    chk(o_interrupt_one, 0);
    acc(1, 0, 10'h38e, 0);
    chk(o_vertical_line_counter, 0);
    for (int k = 0; k < 3; k++) begin
      acc(1, 0, TA[k], 9'h1ff);
      chk(o_trigger, 9'h004 >> k);
      tick;
      chk(o_trigger, 0);
    end
    acc(1, 0, 10'h386, 9'h001);
    acc(1, 0, 10'h387, 9'h002);
    i_vertical_acquisition_pulse = 1;
    tick;
    i_vertical_acquisition_pulse = 0;
    for (int k = 0; k < 2; k++) begin
      i_line_start = 1;
      tick;
      i_line_start = 0;
      tick;
      chk(o_pll_hold, !k);
    end
    $display("t_ctrl done");
  endtask
  task t_words;
    acc(1, 0, 10'h388, 9'h0fe);
    chk(o_display, 9'h0fe);
    i_read_enable = 1;
    tick;
    chk(o_read_enable, 0);
    tick;
    chk(o_read_enable, 1);
    acc(1, 0, 10'h393, 9'h05a);
    chk(o_line_quarter_length, 0);
    i_active_start = 1;
    tick;
    i_active_start = 0;
    chk(o_line_quarter_length, 9'h05a);
    {i_bus_d_luma, i_bus_d_chroma, i_active_end} = {8'h11, 8'h22, 1'b1};
    tick;
    i_active_end = 0;
    acc(0, 0, 10'h33b, 0);
    chk(o_rdata, 9'h011);
    acc(0, 0, 10'h33c, 0);
    chk(o_rdata, 9'h022);
    acc(0, 0, 10'h385, 0);
    chk(o_rdata, 0);
    acc(1, 0, 10'h391, 9'h001);
    acc(1, 0, 10'h392, 9'h1ab);
    acc(1, 0, 10'h395, 9'h049);
    acc(1, 0, 10'h398, 9'h007);
    acc(1, 0, 10'h394, 9'h001);
    chk(o_field_restart, 1);
    chk(o_backend_clock_half, 1);
    chk(o_second_bus_field_start, 9'h1ab);
    chk(o_analog_path_switch, 9'h049);
    chk(o_conv_test, 9'h007);
    $display("t_words done");
  endtask
  task t_subbus;
    i_transmit_busy = 1;
    acc(1, 1, 10'h098, 9'h082);
    chk(o_bit_rate_select, 1);
    acc(0, 1, 10'h098, 0);
    chk(o_rdata, 9'h083);
    i_power_on_reset = 1;
    tick;
    {i_power_on_reset, i_transmit_busy} = 2'h0;
    acc(0, 1, 10'h098, 0);
    chk(o_rdata, 0);
    i_inbound_start = 1;
    tick;
    i_inbound_start = 0;
    acc(0, 1, 10'h098, 0);
    chk(o_rdata, 9'h002);
    {i_inbound_data, i_inbound_done} = {8'ha5, 1'b1};
    tick;
    i_inbound_done = 0;
    acc(0, 1, 10'h09b, 0);
    chk(o_rdata, 9'h0a5);
    acc(1, 1, 10'h099, 9'h012);
    chk(o_subbus_tx_address, 9'h012);
    acc(1, 1, 10'h09a, 9'h034);
    chk(o_subbus_tx_start, 1);
    chk(o_subbus_tx_data, 9'h034);
    $display("t_subbus done");
  endtask
  task stop_test;
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (5) tick;
    i_reset_n = 1;
    t_ctrl;
    t_words;
    t_subbus;
    stop_test;
  end
endmodule // tb
